/* pkg/lcm_map.svh */
`ifndef LCM_MAP_SVH
`define LCM_MAP_SVH
// primary and secondary field codes
`define LCM_CRN_MAINT     4'h7
`define LCM_CRM_WFI       4'h0
`define LCM_CRM_ICACHE    4'h5
`define LCM_CRM_DCACHE    4'h6
`define LCM_CRM_BOTH      4'h7
`define LCM_CRM_XLATE     4'h8
`define LCM_CRM_CLEAN     4'ha
`define LCM_CRM_CLNINV    4'he
// opcode codes
`define LCM_OP_ALL        3'h0
`define LCM_OP_MVA        3'h1
`define LCM_OP_SETWAY     3'h2
`define LCM_OP_WFI        3'h4
`define LCM_OP_PFLUSH     3'h4
`define LCM_OP_SYNC       3'h4
`define LCM_OP_ORDER      3'h5
`define LCM_OP_BTC_ALL    3'h6
`define LCM_OP_BTC_ONE    3'h7
`define LCM_OPC1_L1       3'h0
// operand field positions
`define LCM_WAY_HI        31
`define LCM_WAY_LO        30
`define LCM_SET_LO        5
`define LCM_LINE_LO       5
`define LCM_BTC_LO        3
`define LCM_S_16KB        7
`define LCM_S_32KB        8
`define LCM_S_64KB        9
`define LCM_RET_OFFSET    32'h0000_0004
`endif

/* pkg/lcm_pkg.sv */
package lcm_pkg;
  typedef enum logic [2:0]
  {
    LCM_ST_IDLE  = 3'b000,
    LCM_ST_WORK  = 3'b001,
    LCM_ST_DRAIN = 3'b010,
    LCM_ST_WFI   = 3'b011,
    LCM_ST_XLATE = 3'b100
  } lcm_state_t;

  typedef enum logic [3:0]
  {
    LCM_OP_NONE    = 4'h0,
    LCM_OP_INV     = 4'h1,
    LCM_OP_CLEAN   = 4'h2,
    LCM_OP_CLNINV  = 4'h3,
    LCM_OP_BTC     = 4'h4,
    LCM_OP_PFB     = 4'h5,
    LCM_OP_SYNCB   = 4'h6,
    LCM_OP_ORDERB  = 4'h7,
    LCM_OP_WAITI   = 4'h8,
    LCM_OP_XLATE   = 4'h9
  } lcm_kind_t;

  typedef enum logic [1:0]
  {
    LCM_SC_ALL    = 2'b00,
    LCM_SC_MVA    = 2'b01,
    LCM_SC_SETWAY = 2'b10
  } lcm_scope_t;
endpackage

/* src/lcm_maint.sv */
`include "lcm_map.svh"
`timescale 1ns/10ps
`default_nettype none
module lcm_maint
#(
  parameter int CACHE_KB = 32
)
(
  input  wire logic               I_CLK_SYS,
  input  wire logic               I_RST,
  // coprocessor write from the core
  input  wire logic               I_WR_VALID,
  input  wire logic [2:0]         I_WR_OPC1,
  input  wire logic [3:0]         I_WR_CRN,
  input  wire logic [3:0]         I_WR_CRM,
  input  wire logic [2:0]         I_WR_OPC2,
  input  wire logic [31:0]        I_WR_DATA,
  input  wire logic [31:0]        I_WR_VADDR,
  input  wire logic [31:0]        I_WR_PC,
  input  wire logic               I_USER_MODE,
  input  wire logic               I_TLB_WALK_EN,
  output logic                    o_wr_ready,
  output logic                    o_undef,
  output logic                    o_stall,
  output logic                    o_refetch,
  // interrupt and debug wake
  input  wire logic               I_IRQ,
  input  wire logic               I_DBG_REQ,
  input  wire logic               I_DBG_EN,
  output logic                    o_low_power,
  output logic                    o_ret_valid,
  output logic [31:0]             o_ret_link,
  // memory system status
  input  wire logic               I_MEM_IDLE,
  input  wire logic               I_MAINT_IDLE,
  output logic                    o_order_fence,
  // cache array command
  output logic                    o_cache_req,
  output lcm_pkg::lcm_kind_t      o_cache_kind,
  output lcm_pkg::lcm_scope_t     o_cache_scope,
  output logic                    o_cache_icache,
  output logic                    o_cache_dcache,
  output logic                    o_cache_btc,
  output logic                    o_cache_incl_locked,
  output logic [31:0]             o_cache_addr,
  output logic [1:0]              o_cache_way,
  output logic [8:0]              o_cache_set,
  input  wire logic               I_CACHE_DONE,
  // translation path
  output logic                    o_tlb_req,
  output logic [31:0]             o_tlb_vaddr,
  output logic                    o_tlb_bypass_reloc,
  output logic                    o_tlb_xlate,
  output logic [1:0]              o_tlb_perm,
  input  wire logic               I_TLB_DONE,
  input  wire logic               I_TLB_MISS,
  input  wire logic [31:0]        I_TLB_PA,
  output logic                    o_tlb_miss_exc,
  output logic                    o_walk_req,
  output logic                    o_pa_wr,
  output logic [31:0]             o_pa_result
);
  import lcm_pkg::*;

  localparam int S_TOP = (CACHE_KB == 16) ? `LCM_S_16KB :
                         (CACHE_KB == 32) ? `LCM_S_32KB : `LCM_S_64KB;

  if (CACHE_KB != 16 && CACHE_KB != 32 && CACHE_KB != 64)
  begin : g_bad_size
    $error("lcm_maint: cache size must be 16, 32 or 64");
  end

  function automatic logic is_all(input logic [2:0] op);
    is_all = (op == `LCM_OP_ALL);
  endfunction

  // decode
  wire l1_sel    = I_WR_VALID && (I_WR_CRN == `LCM_CRN_MAINT)
                   && (I_WR_OPC1 == `LCM_OPC1_L1);
  wire c0_wfi    = (I_WR_CRM == `LCM_CRM_WFI) && (I_WR_OPC2 == `LCM_OP_WFI);
  wire c5_all    = (I_WR_CRM == `LCM_CRM_ICACHE) && is_all(I_WR_OPC2);
  wire c5_mva    = (I_WR_CRM == `LCM_CRM_ICACHE) && (I_WR_OPC2 == `LCM_OP_MVA);
  wire c5_sw     = (I_WR_CRM == `LCM_CRM_ICACHE) && (I_WR_OPC2 == `LCM_OP_SETWAY);
  wire c5_pfb    = (I_WR_CRM == `LCM_CRM_ICACHE) && (I_WR_OPC2 == `LCM_OP_PFLUSH);
  wire c5_btca   = (I_WR_CRM == `LCM_CRM_ICACHE) && (I_WR_OPC2 == `LCM_OP_BTC_ALL);
  wire c5_btc1   = (I_WR_CRM == `LCM_CRM_ICACHE) && (I_WR_OPC2 == `LCM_OP_BTC_ONE);
  wire c6_op     = (I_WR_CRM == `LCM_CRM_DCACHE) && (I_WR_OPC2 <= `LCM_OP_SETWAY);
  wire c7_all    = (I_WR_CRM == `LCM_CRM_BOTH) && is_all(I_WR_OPC2);
  wire c8_xl     = (I_WR_CRM == `LCM_CRM_XLATE) && (I_WR_OPC2[2] == 1'b0);
  wire c10_op    = (I_WR_CRM == `LCM_CRM_CLEAN) && (I_WR_OPC2 <= `LCM_OP_SETWAY);
  wire c10_sync  = (I_WR_CRM == `LCM_CRM_CLEAN) && (I_WR_OPC2 == `LCM_OP_SYNC);
  wire c10_ord   = (I_WR_CRM == `LCM_CRM_CLEAN) && (I_WR_OPC2 == `LCM_OP_ORDER);
  wire c14_op    = (I_WR_CRM == `LCM_CRM_CLNINV) && (I_WR_OPC2 <= `LCM_OP_SETWAY);
  wire user_ok   = c5_pfb || c10_sync || c10_ord;
  wire known     = c0_wfi || c5_all || c5_mva || c5_sw || c5_pfb || c5_btca || c5_btc1
                   || c6_op || c7_all || c8_xl || c10_op || c10_sync || c10_ord || c14_op;
  wire priv_fail = l1_sel && known && I_USER_MODE && !user_ok;
  wire take      = l1_sel && known && !priv_fail && o_wr_ready;

  wire lcm_kind_t  dec_kind =
    c0_wfi   ? LCM_OP_WAITI  :
    c5_pfb   ? LCM_OP_PFB    :
    c10_sync ? LCM_OP_SYNCB  :
    c10_ord  ? LCM_OP_ORDERB :
    c8_xl    ? LCM_OP_XLATE  :
    (c5_btca || c5_btc1) ? LCM_OP_BTC :
    c10_op   ? LCM_OP_CLEAN  :
    c14_op   ? LCM_OP_CLNINV : LCM_OP_INV;
  wire lcm_scope_t dec_scope =
    (c5_btc1 || I_WR_OPC2 == `LCM_OP_MVA) ? LCM_SC_MVA :
    (I_WR_OPC2 == `LCM_OP_SETWAY) ? LCM_SC_SETWAY : LCM_SC_ALL;
  wire dec_ic  = c5_all || c5_mva || c5_sw || c7_all;
  wire dec_dc  = c6_op || c7_all || c10_op || c14_op;
  wire dec_btc = c5_all || c5_btca || c5_btc1 || c7_all;
  wire dec_cache = dec_ic || dec_dc || dec_btc;
  // address operands: low bits dropped, relocation bypassed
  wire [31:0] line_addr = {I_WR_DATA[31:`LCM_LINE_LO], 5'h00};
  wire [31:0] btc_addr  = {I_WR_DATA[31:`LCM_BTC_LO], 3'h0};
  wire [31:0] dec_addr  = c5_btc1 ? btc_addr : line_addr;
  wire [8:0]  sw_set    = 9'(I_WR_DATA[S_TOP+4:`LCM_SET_LO]);
  wire        dec_mva   = (dec_scope == LCM_SC_MVA) && dec_cache;

  lcm_state_t st_ff, nxt_st;
  lcm_kind_t  kind_ff;
  lcm_scope_t scope_ff;
  logic        ic_ff;
  logic        dc_ff;
  logic        btc_ff;
  logic        tlb_ff;
  logic        undef_ff;
  logic        refetch_ff;
  logic        ret_v_ff;
  logic        pa_wr_ff;
  logic        miss_ff;
  logic        walk_ff;
  logic [31:0] addr_ff;
  logic [31:0] pc_ff;
  logic [31:0] ret_ff;
  logic [31:0] pa_ff;
  logic [1:0]  way_ff;
  logic [1:0]  perm_ff;
  logic [8:0]  set_ff;

  wire wake      = I_IRQ || (I_DBG_REQ && I_DBG_EN);
  wire whole_op  = (st_ff == LCM_ST_WORK) && (scope_ff == LCM_SC_ALL);
  wire interrupt = whole_op && I_IRQ && !I_CACHE_DONE;
  wire work_end   = I_CACHE_DONE || interrupt;
  wire drain_done = I_MEM_IDLE && I_MAINT_IDLE;
  wire xl_done    = (st_ff == LCM_ST_XLATE) && I_TLB_DONE;
  wire xl_hit     = xl_done && !I_TLB_MISS;
  wire xl_trap    = xl_done && I_TLB_MISS && !I_TLB_WALK_EN;
  wire xl_walk    = xl_done && I_TLB_MISS && I_TLB_WALK_EN;
  wire pa_load    = xl_hit && (kind_ff == LCM_OP_XLATE);
  wire pfb_take   = take && (dec_kind == LCM_OP_PFB);
  wire order_take = take && (dec_kind == LCM_OP_ORDERB);
  wire [31:0] ret_next = pc_ff + `LCM_RET_OFFSET;

  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      LCM_ST_IDLE:
        if (take)
        begin
          if (dec_kind == LCM_OP_WAITI)
            nxt_st = LCM_ST_WFI;
          else if (dec_kind == LCM_OP_SYNCB)
            nxt_st = LCM_ST_DRAIN;
          else if (dec_kind == LCM_OP_XLATE || dec_mva)
            nxt_st = LCM_ST_XLATE;
          else if (dec_cache)
            nxt_st = LCM_ST_WORK;
        end
      LCM_ST_XLATE:
        if (I_TLB_DONE)
        begin
          if (I_TLB_MISS && !I_TLB_WALK_EN)
            nxt_st = LCM_ST_IDLE;
          else if (!I_TLB_MISS && kind_ff != LCM_OP_XLATE)
            nxt_st = LCM_ST_WORK;
          else if (!I_TLB_MISS)
            nxt_st = LCM_ST_IDLE;
        end
      LCM_ST_WORK:
        if (work_end)
          nxt_st = LCM_ST_IDLE;
      LCM_ST_DRAIN:
        if (drain_done)
          nxt_st = LCM_ST_IDLE;
      LCM_ST_WFI:
        if (wake)
          nxt_st = LCM_ST_IDLE;
      default:
        nxt_st = LCM_ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
      st_ff <= LCM_ST_IDLE;
    else
      st_ff <= nxt_st;
  end

  // command capture
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      kind_ff  <= LCM_OP_NONE;
      scope_ff <= LCM_SC_ALL;
      ic_ff    <= 1'b0;
      dc_ff    <= 1'b0;
      btc_ff   <= 1'b0;
    end
    else if (take)
    begin
      kind_ff  <= dec_kind;
      scope_ff <= dec_scope;
      ic_ff    <= dec_ic;
      dc_ff    <= dec_dc;
      btc_ff   <= dec_btc;
    end
  end

  // operand capture
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      addr_ff  <= 32'h0000_0000;
      pc_ff    <= 32'h0000_0000;
      way_ff   <= 2'h0;
      set_ff   <= 9'h000;
      perm_ff  <= 2'h0;
    end
    else if (take)
    begin
      addr_ff  <= (dec_kind == LCM_OP_XLATE) ? I_WR_VADDR : dec_addr;
      pc_ff    <= I_WR_PC;
      way_ff   <= I_WR_DATA[`LCM_WAY_HI:`LCM_WAY_LO];
      set_ff   <= sw_set;
      perm_ff  <= I_WR_OPC2[1:0];
    end
  end

  // one-cycle result pulses
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      tlb_ff     <= 1'b0;
      undef_ff   <= 1'b0;
      refetch_ff <= 1'b0;
      ret_v_ff   <= 1'b0;
      pa_wr_ff   <= 1'b0;
      miss_ff    <= 1'b0;
      walk_ff    <= 1'b0;
    end
    else
    begin
      tlb_ff     <= (nxt_st == LCM_ST_XLATE) && (st_ff != LCM_ST_XLATE);
      undef_ff   <= priv_fail && o_wr_ready;
      refetch_ff <= pfb_take;
      ret_v_ff   <= interrupt;
      pa_wr_ff   <= pa_load;
      miss_ff    <= xl_trap;
      walk_ff    <= xl_walk;
    end
  end

  // return link of an interrupted whole-cache operation
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
      ret_ff <= 32'h0000_0000;
    else if (interrupt)
      ret_ff <= ret_next;
  end

  // physical address result
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
      pa_ff <= 32'h0000_0000;
    else if (pa_load)
      pa_ff <= I_TLB_PA;
  end

  // cache command: address ops only reach here after a hit-or-walked lookup
  assign o_cache_req         = (st_ff == LCM_ST_WORK);
  assign o_cache_kind        = kind_ff;
  assign o_cache_scope       = scope_ff;
  assign o_cache_icache      = ic_ff;
  assign o_cache_dcache      = dc_ff;
  assign o_cache_btc         = btc_ff;
  assign o_cache_incl_locked = (kind_ff == LCM_OP_INV) || (kind_ff == LCM_OP_CLNINV);
  assign o_cache_addr        = addr_ff;
  assign o_cache_way         = way_ff;
  assign o_cache_set         = set_ff;

  assign o_tlb_req           = tlb_ff;
  assign o_tlb_vaddr         = addr_ff;
  assign o_tlb_bypass_reloc  = (kind_ff != LCM_OP_XLATE);
  assign o_tlb_xlate         = (kind_ff == LCM_OP_XLATE);
  assign o_tlb_perm          = perm_ff;
  assign o_tlb_miss_exc      = miss_ff;
  assign o_walk_req          = walk_ff;
  assign o_pa_wr             = pa_wr_ff;
  assign o_pa_result         = pa_ff;

  assign o_wr_ready          = (st_ff == LCM_ST_IDLE);
  assign o_stall             = (st_ff != LCM_ST_IDLE);
  assign o_undef             = undef_ff;
  assign o_refetch           = refetch_ff;
  assign o_low_power         = (st_ff == LCM_ST_WFI);
  assign o_ret_valid         = ret_v_ff;
  assign o_ret_link          = ret_ff;
  assign o_order_fence       = order_take;
endmodule // lcm_maint
`default_nettype wire

/* sim/lcm_maint_props.sv */
`timescale 1ns/10ps
`default_nettype none
module lcm_maint_props
#(
  parameter int CACHE_KB = 32
)
(
  input wire logic               I_CLK_SYS,
  input wire logic               I_RST,
  input wire logic               I_WR_VALID,
  input wire logic [2:0]         I_WR_OPC1,
  input wire logic [3:0]         I_WR_CRN,
  input wire logic [3:0]         I_WR_CRM,
  input wire logic [2:0]         I_WR_OPC2,
  input wire logic [31:0]        I_WR_DATA,
  input wire logic [31:0]        I_WR_PC,
  input wire logic               I_USER_MODE,
  input wire logic               I_IRQ,
  input wire logic               I_MEM_IDLE,
  input wire logic               o_wr_ready,
  input wire logic               o_undef,
  input wire logic               o_refetch,
  input wire logic               o_low_power,
  input wire logic               o_ret_valid,
  input wire logic [31:0]        o_ret_link,
  input wire logic               o_order_fence,
  input wire logic               o_cache_req,
  input wire lcm_pkg::lcm_kind_t o_cache_kind,
  input wire logic [1:0]         o_cache_way,
  input wire logic [8:0]         o_cache_set
);
  import lcm_pkg::*;
  localparam int S = (CACHE_KB == 16) ? 7 : ((CACHE_KB == 64) ? 9 : 8);
  localparam logic [31:0] SMASK = (32'h1 << S) - 32'h1;
  logic [31:0] pc_ff;
  wire tk = I_WR_VALID && o_wr_ready && I_WR_OPC1 == 3'h0 && I_WR_CRN == 4'h7;
  wire c10 = I_WR_CRM == 4'ha;
  wire free = (c10 && I_WR_OPC2[2:1] == 2'b10) || (I_WR_CRM == 4'h5 && I_WR_OPC2 == 3'h4);
  always_ff @(posedge I_CLK_SYS)
    if (tk)
      pc_ff <= I_WR_PC;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  sequence s_sync_tk;
    tk && c10 && I_WR_OPC2 == 3'h4 && !I_MEM_IDLE;
  endsequence
  sequence s_wfi_tk;
    tk && !I_USER_MODE && I_WR_CRM == 4'h0 && I_WR_OPC2 == 3'h4;
  endsequence
  user_priv_undef_a: assert property (
    tk && I_USER_MODE && !free && I_WR_CRM inside {4'h5, 4'h6, 4'ha, 4'he}
    && I_WR_OPC2 <= 3'h2 |=> o_undef && !o_cache_req)
    else $error("privileged op in user mode not refused");
  pfb_refetch_a: assert property (
    tk && I_WR_CRM == 4'h5 && I_WR_OPC2 == 3'h4 |=> o_refetch)
    else $error("prefetch flush without refetch");
  order_fence_a: assert property (
    tk && c10 && I_WR_OPC2 == 3'h5 |-> o_order_fence && o_wr_ready)
    else $error("order barrier without fence");
  clean_all_a: assert property (
    tk && !I_USER_MODE && c10 && I_WR_OPC2 == 3'h0 |=> o_cache_req && o_cache_kind == LCM_OP_CLEAN)
    else $error("clean of whole cache not started");
  set_way_a: assert property (
    tk && !I_USER_MODE && I_WR_CRM == 4'h6 && I_WR_OPC2 == 3'h2 |=> o_cache_req
    && o_cache_way == 2'($past(I_WR_DATA) >> 30) && o_cache_set == 9'(($past(I_WR_DATA) >> 5) & SMASK))
    else $error("set or way field wrong");
  sync_hold_a: assert property (
    s_sync_tk |=> !o_wr_ready until_with I_MEM_IDLE)
    else $error("sync barrier released early");
  wfi_enter_a: assert property (
    s_wfi_tk |=> o_low_power)
    else $error("wait for interrupt not entered");
  wfi_wake_a: assert property (
    o_low_power && I_IRQ |-> ##[1:2] !o_low_power)
    else $error("no wake on interrupt");
  ret_link_a: assert property (
    o_ret_valid |-> o_ret_link == pc_ff + 32'h4 && !o_cache_req)
    else $error("return link wrong");
  reserved_noop_a: assert property (
    I_WR_VALID && o_wr_ready && (I_WR_OPC1 != 3'h0 || I_WR_CRM == 4'h3)
    |=> o_wr_ready && !o_cache_req && !o_undef && !o_refetch)
    else $error("reserved command had an effect");
endmodule // lcm_maint_props
bind lcm_maint lcm_maint_props #(.CACHE_KB(CACHE_KB)) lcm_maint_props_inst (.I_CLK_SYS, .I_RST,
  .I_WR_VALID, .I_WR_OPC1, .I_WR_CRN, .I_WR_CRM, .I_WR_OPC2, .I_WR_DATA, .I_WR_PC, .I_USER_MODE,
  .I_IRQ, .I_MEM_IDLE, .o_wr_ready, .o_undef, .o_refetch, .o_low_power, .o_ret_valid,
  .o_ret_link, .o_order_fence, .o_cache_req, .o_cache_kind, .o_cache_way, .o_cache_set);
`default_nettype wire

/* sim/lcm_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module lcm_mem_model
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_cache_req,
  input  wire logic        i_tlb_req,
  input  wire logic        i_walk_req,
  input  wire logic        i_miss,
  input  wire logic [3:0]  i_dly,
  input  wire logic [31:0] i_vaddr,
  output logic             o_cache_done,
  output logic             o_tlb_done,
  output logic             o_tlb_miss,
  output logic [31:0]      o_tlb_pa
);
  logic [3:0] c_cnt, t_cnt;
  logic       t_busy, walk;
  wire        t_end = t_busy && t_cnt == i_dly;
  // answers after i_dly cycles; lookup data is garbage outside the done cycle
  always @(posedge i_clk)
  begin
    c_cnt <= (i_cache_req && !o_cache_done) ? c_cnt + 4'h1 : 4'h0;
    o_cache_done <= i_cache_req && !o_cache_done && c_cnt == i_dly && !i_rst;
    o_tlb_done <= t_end && !i_rst;
    o_tlb_miss <= t_end ? i_miss && !walk : !o_tlb_miss;
    o_tlb_pa <= t_end ? i_vaddr ^ 32'h8000_0000 : ~o_tlb_pa;
    t_cnt <= t_busy ? t_cnt + 4'h1 : 4'h0;
    t_busy <= (i_tlb_req || i_walk_req || (t_busy && !t_end)) && !i_rst;
    if (i_tlb_req || i_walk_req)
      walk <= i_walk_req;
  end
endmodule // lcm_mem_model
`default_nettype wire

/* sim/l1_cache_maintenance_ops_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WT(c) begin n = 0; while (!(c) && n < 300) begin @(posedge I_CLK_SYS); #1; n++; end \
  if (!(c)) begin n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1); end end
module l1_cache_maintenance_ops_tb_top;
  import lcm_pkg::*;
  logic I_CLK_SYS = '0, I_RST = '1, I_WR_VALID = '0, I_USER_MODE = '0, I_TLB_WALK_EN = '0;
  logic I_IRQ = '0, I_DBG_REQ = '0, I_DBG_EN = '0, I_MEM_IDLE = '1, I_MAINT_IDLE = '1, miss = '0;
  logic I_CACHE_DONE, I_TLB_DONE, I_TLB_MISS, o_wr_ready, o_undef, o_stall, o_refetch;
  logic o_low_power, o_ret_valid, o_order_fence, o_cache_req, o_cache_icache, o_cache_dcache;
  logic o_cache_btc, o_cache_incl_locked, o_tlb_req, o_tlb_bypass_reloc, o_tlb_xlate;
  logic o_tlb_miss_exc, o_walk_req, o_pa_wr;
  logic [1:0] o_cache_way, o_tlb_perm;
  logic [2:0] I_WR_OPC1 = '0, I_WR_OPC2 = '0;
  logic [3:0] I_WR_CRN = 4'h7, I_WR_CRM = '0, dly = 4'h2;
  logic [8:0] o_cache_set;
  logic [31:0] I_WR_DATA = '0, I_WR_VADDR = '0, I_WR_PC = '0, I_TLB_PA, o_ret_link;
  logic [31:0] o_cache_addr, o_tlb_vaddr, o_pa_result;
  lcm_kind_t o_cache_kind;
  lcm_scope_t o_cache_scope;
  int n_errors = 0, total_checks = 0, n;
  logic fence_ff = 1'b0;
  // whole ops, then set/way and address ops; icache line flush precedes btc entry flush
  logic [3:0] wm[6] = '{4'h5, 4'h5, 4'h6, 4'h7, 4'ha, 4'he};
  logic [2:0] wo[6] = '{3'h0, 3'h6, 3'h0, 3'h0, 3'h0, 3'h0};
  lcm_kind_t wk[6] = '{LCM_OP_INV, LCM_OP_BTC, LCM_OP_INV, LCM_OP_INV, LCM_OP_CLEAN, LCM_OP_CLNINV};
  logic [2:0] wf[6] = '{3'b101, 3'b001, 3'b010, 3'b111, 3'b010, 3'b010};
  logic [3:0] sm[4] = '{4'h5, 4'h6, 4'ha, 4'he};
  logic [3:0] am[5] = '{4'h5, 4'h5, 4'h6, 4'ha, 4'he};
  logic [2:0] ao[5] = '{3'h1, 3'h7, 3'h1, 3'h1, 3'h1};
  lcm_maint #(.CACHE_KB(32)) lcm_maint_inst (.I_CLK_SYS, .I_RST, .I_WR_VALID, .I_WR_OPC1,
    .I_WR_CRN, .I_WR_CRM, .I_WR_OPC2, .I_WR_DATA, .I_WR_VADDR, .I_WR_PC, .I_USER_MODE,
    .I_TLB_WALK_EN, .o_wr_ready, .o_undef, .o_stall, .o_refetch, .I_IRQ, .I_DBG_REQ, .I_DBG_EN,
    .o_low_power, .o_ret_valid, .o_ret_link, .I_MEM_IDLE, .I_MAINT_IDLE, .o_order_fence,
    .o_cache_req, .o_cache_kind, .o_cache_scope, .o_cache_icache, .o_cache_dcache, .o_cache_btc,
    .o_cache_incl_locked, .o_cache_addr, .o_cache_way, .o_cache_set, .I_CACHE_DONE, .o_tlb_req,
    .o_tlb_vaddr, .o_tlb_bypass_reloc, .o_tlb_xlate, .o_tlb_perm, .I_TLB_DONE, .I_TLB_MISS,
    .I_TLB_PA, .o_tlb_miss_exc, .o_walk_req, .o_pa_wr, .o_pa_result);
  lcm_mem_model lcm_mem_model_inst (.i_clk(I_CLK_SYS), .i_rst(I_RST), .i_cache_req(o_cache_req),
    .i_tlb_req(o_tlb_req), .i_walk_req(o_walk_req), .i_miss(miss), .i_dly(dly),
    .i_vaddr(o_tlb_vaddr), .o_cache_done(I_CACHE_DONE), .o_tlb_done(I_TLB_DONE),
    .o_tlb_miss(I_TLB_MISS), .o_tlb_pa(I_TLB_PA));
  always #10 I_CLK_SYS = ~I_CLK_SYS;
  // remembers whether the fence pulse stood in the cycle before the last edge
  always @(posedge I_CLK_SYS) fence_ff <= o_order_fence;
  task automatic results;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // holds the write until the edge that takes it; b keeps valid up for a back-to-back write
  task automatic wr(input logic [3:0] m, input logic [2:0] p, input logic [31:0] d,
                    input logic u = 1'b0, input logic b = 1'b0);
    I_WR_CRM <= m;
    I_WR_OPC2 <= p;
    I_WR_DATA <= d;
    I_USER_MODE <= u;
    I_WR_VALID <= 1'b1;
    n = 0;
    @(negedge I_CLK_SYS);
    while (o_wr_ready !== 1'b1 && n < 300)
    begin
      @(negedge I_CLK_SYS);
      n++;
    end
    if (o_wr_ready !== 1'b1)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, o_wr_ready, 1'b1);
    end
    @(posedge I_CLK_SYS);
    if (!b)
      I_WR_VALID <= 1'b0;
    #1;
  endtask
  initial
  begin
    #300000;
    n_errors++;
    results();
  end
  initial
  begin
    repeat (12) @(posedge I_CLK_SYS);
    I_RST <= 1'b0;
    #1;
    foreach (wm[i])
    begin
      wr(wm[i], wo[i], 32'hffff_ffff);
      `CHK({o_cache_req, o_cache_kind, o_cache_scope}, {1'b1, wk[i], LCM_SC_ALL})
      `CHK({o_cache_icache, o_cache_dcache, o_cache_btc}, wf[i])
      if (wk[i] == LCM_OP_INV)
        `CHK(o_cache_incl_locked, 1'b1)
      `WT(o_wr_ready)
    end
    foreach (sm[i])
    begin
      wr(sm[i], 3'h2, 32'ha5a5_4aff);
      `CHK({o_cache_way, o_cache_set, o_cache_scope}, {2'h2, 9'h057, LCM_SC_SETWAY})
      `WT(o_wr_ready)
    end
    foreach (am[i])
    begin
      wr(am[i], ao[i], 32'h1234_567f);
      `WT(o_tlb_req)
      `CHK({o_tlb_bypass_reloc, o_tlb_xlate, o_tlb_req}, 3'b101)
      `WT(o_cache_req)
      `CHK(o_cache_addr, (ao[i] == 3'h7) ? 32'h1234_5678 : 32'h1234_5660)
      `WT(o_wr_ready)
    end
    miss <= 1'b1;
    wr(4'h6, 3'h1, 32'h0000_1000);
    `WT(o_tlb_miss_exc)
    `CHK({o_tlb_miss_exc, o_cache_req}, 2'b10)
    `WT(o_wr_ready)
    I_TLB_WALK_EN <= 1'b1;
    wr(4'ha, 3'h1, 32'h0000_1000);
    `WT(o_walk_req)
    `CHK(o_walk_req, 1'b1)
    `WT(o_cache_req)
    `CHK(o_cache_req, 1'b1)
    `WT(o_wr_ready)
    miss <= 1'b0;
    I_WR_VADDR <= 32'h4000_1234;
    wr(4'h8, 3'h3, 32'h0bad_0000);
    `WT(o_pa_wr)
    `CHK({o_tlb_vaddr, o_pa_result}, {32'h4000_1234, 32'hc000_1234})
    `CHK({o_pa_wr, o_tlb_xlate, o_tlb_bypass_reloc, o_tlb_perm}, 5'b11011)
    `WT(o_wr_ready)
    wr(4'h6, 3'h0, 32'h0, 1'b1);
    `CHK({o_undef, o_cache_req}, 2'b10)
    wr(4'h5, 3'h4, 32'h0, 1'b1, 1'b1);
    `CHK({o_refetch, o_undef, fence_ff}, 3'b100)
    wr(4'ha, 3'h5, 32'h0, 1'b1);
    `CHK({o_undef, o_wr_ready, fence_ff}, 3'b011)
    I_MEM_IDLE <= 1'b0;
    I_MAINT_IDLE <= 1'b0;
    wr(4'ha, 3'h4, 32'h0, 1'b1);
    repeat (5) @(posedge I_CLK_SYS);
    #1;
    `CHK({o_wr_ready, o_undef, o_stall}, 3'b001)
    I_MEM_IDLE <= 1'b1;
    repeat (3) @(posedge I_CLK_SYS);
    #1;
    `CHK({o_wr_ready, o_stall}, 2'b01)
    I_MAINT_IDLE <= 1'b1;
    `WT(o_wr_ready)
    `CHK({o_wr_ready, o_stall}, 2'b10)
    dly <= 4'hf;
    I_WR_PC <= 32'h0000_0100;
    wr(4'he, 3'h0, 32'h0);
    repeat (3) @(posedge I_CLK_SYS);
    I_IRQ <= 1'b1;
    `WT(o_ret_valid)
    `CHK({o_ret_valid, o_ret_link}, {1'b1, 32'h0000_0104})
    I_IRQ <= 1'b0;
    `WT(o_wr_ready)
    wr(4'h0, 3'h4, 32'hffff_ffff);
    I_DBG_REQ <= 1'b1;
    repeat (3) @(posedge I_CLK_SYS);
    #1;
    `CHK(o_low_power, 1'b1)
    I_DBG_EN <= 1'b1;
    `WT(!o_low_power)
    `CHK(o_low_power, 1'b0)
    I_DBG_REQ <= 1'b0;
    wr(4'h0, 3'h4, 32'h0);
    I_IRQ <= 1'b1;
    `WT(!o_low_power)
    `CHK(o_low_power, 1'b0)
    I_IRQ <= 1'b0;
    wr(4'h3, 3'h0, 32'h0);
    `CHK({o_wr_ready, o_cache_req, o_tlb_req}, 3'b100)
    I_WR_OPC1 <= 3'h1;
    wr(4'ha, 3'h0, 32'h0);
    `CHK({o_wr_ready, o_cache_req}, 2'b10)
    results();
  end
endmodule // l1_cache_maintenance_ops_tb_top
`default_nettype wire
